// >>> hdl/smc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the misc CSR group
// Assumes: Included by bare name from the design file
// Notes:   Definitions only
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// ----------------------------------------------------------------
// Register word offsets (byte address)
// ----------------------------------------------------------------
`define SMC_OFS_TIMER_CFG     8'h8C
`define SMC_OFS_TIMER_VIEW    8'h90
`define SMC_OFS_WORD_ORDER    8'h98
`define SMC_OFS_FREE_TICK     8'h9C
`define SMC_OFS_DROP_TALLY    8'hA0
`define SMC_OFS_INNER_CMD     8'hA4
`define SMC_OFS_INNER_VALUE   8'hA8

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define SMC_CMD_BUSY_BIT      31
`define SMC_CMD_RNW_BIT       30
`define SMC_CFG_RUN_BIT       29
`define SMC_HALF_BUSY_BIT     15
`define SMC_HALF_RNW_BIT      14
`define SMC_HALF_RUN_BIT      13
`define SMC_CMD_RSVD_W        22
`define SMC_CFG_RSVD_W        13

// ----------------------------------------------------------------
// Reset values and special patterns
// ----------------------------------------------------------------
`define SMC_TIMER_RESET       16'hFFFF
`define SMC_SWAP_ALL_ONES     32'hFFFF_FFFF
`define SMC_DROP_HALFWAY      32'h7FFF_FFFF
`define SMC_ZERO32            32'h0000_0000
`define SMC_ZERO16            16'h0000
`define SMC_ONE32             32'h0000_0001
`define SMC_ONE16             16'h0001

// ----------------------------------------------------------------
// Timing: system clock and slow count clock, in MHz
// ----------------------------------------------------------------
`define SMC_CLK_MHZ           250
`define SMC_SCLK_MHZ          25
`define SMC_SCLK_DIV          (`SMC_CLK_MHZ / `SMC_SCLK_MHZ)
`define SMC_DIV_W             4

`endif

// >>> hdl/smc_pkg.sv
// Purpose: Types of the misc CSR group
// Assumes: Widths match smc_defs.svh
// Notes:   State struct holds every flop of the block
package smc_pkg;

   // ----------------------------------------------------------------
   // Inner register transfer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SMC_XFER_IDLE = 2'b01,
      SMC_XFER_WAIT = 2'b10
   } smc_xfer_t;

   // ----------------------------------------------------------------
   // Whole block state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  tick_div;
      logic        tick;
      logic [31:0] free_cnt;
      logic [31:0] free_snap;
      logic        free_held;
      logic [31:0] drop_cnt;
      logic [31:0] drop_snap;
      logic        drop_held;
      logic        drop_half;
      logic [31:0] swap;
      logic        tmr_run;
      logic [15:0] tmr_load;
      logic [15:0] tmr_cnt;
      logic        tmr_expired;
      smc_xfer_t   xfer;
      logic        cmd_rnw;
      logic [7:0]  cmd_addr;
      logic [31:0] inner_value;
      logic        inner_req;
      logic [15:0] rdata;
      logic [15:0] tx_high;
      logic        tx_phase;
      logic [15:0] tx_half;
      logic        tx_half_valid;
      logic        tx_word_ready;
      logic [15:0] rx_low;
      logic        rx_have_low;
      logic [31:0] rx_word;
      logic        rx_word_valid;
   } smc_state_t;

endpackage

// >>> hdl/smc_csr_group.sv
// Purpose: System misc CSR group: timer view, word order, tick and drop counters,
//          indirect path to the inner MAC registers, FIFO word order to the network
// Assumes: Host strobes are one-cycle synchronous pulses on a 16-bit bus
// Notes:   Read data appears one clock after the read strobe
//          Tick and tally reads pair up: the first half read samples,
//          the second returns the sample and re-arms the capture
//          Command and value writes are dropped while a transfer is busy
//          Timer counts down at the slow tick rate; expiry is a one-clock pulse
//          Halfway event is a one-clock pulse for an interrupt block elsewhere
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_csr_group
   import smc_pkg::*;
#(
   parameter int SCLK_DIV = `SMC_SCLK_DIV
)(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        host_cs,
   input  wire logic        host_rd,
   input  wire logic        host_wr,
   input  wire logic [7:1]  host_addr,
   input  wire logic [15:0] host_wdata,
   output logic      [15:0] host_rdata,
   input  wire logic        frame_dropped,
   output logic             drop_halfway_event,
   output logic             timer_expired,
   output logic             inner_req,
   output logic             inner_rnw,
   output logic      [7:0]  inner_addr,
   output logic      [31:0] inner_wdata,
   input  wire logic        inner_ack,
   input  wire logic [31:0] inner_rdata,
   input  wire logic [31:0] tx_word,
   input  wire logic        tx_word_valid,
   output logic             tx_word_ready,
   output logic      [15:0] tx_half,
   output logic             tx_half_valid,
   input  wire logic [15:0] rx_half,
   input  wire logic        rx_half_valid,
   output logic      [31:0] rx_word,
   output logic             rx_word_valid
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // One packed struct holds every flop; d is its next value
   smc_state_t q;
   smc_state_t d;

   // Divider wraps at SCLK_DIV-1; the cast keeps the compare at the
   // divider width, so SCLK_DIV above 16 would alias silently
   localparam logic [3:0] DIV_LAST = 4'(SCLK_DIV - 1);

   // Host access decode; chip select qualifies both strobes, so a
   // strobe without select is ignored
   logic [7:0]  byte_ofs;
   logic        upper_sel;
   logic        rd_hit;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic [15:0] rd_half;

   // Word select is the address bit, inverted only by the all-ones pattern
   // Any other pattern, half-written ones included, keeps the plain order
   assign byte_ofs  = {host_addr[7:2], 2'b00};
   assign upper_sel = (q.swap == `SMC_SWAP_ALL_ONES) ? ~host_addr[1]
                                                     : host_addr[1];
   assign rd_hit    = host_cs & host_rd;
   assign wr_hit    = host_cs & host_wr;

   // ----------------------------------------------------------------
   // Register map, byte offsets of each 32-bit register
   // ----------------------------------------------------------------
   //   8C  timer config: run bit 29, preload 15:0
   //   90  timer view: live count in 15:0, upper half reads zero
   //   98  word order: all ones swaps the halves of every access
   //   9C  tick counter: read only, sampled on the first half read
   //   A0  drop tally: read only, cleared by the first half read
   //   A4  inner command: busy 31, read_not_write 30, address 7:0
   //   A8  inner value: data to or from the inner register
   //   Other offsets read as zero and ignore writes

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Counters with a capture read back the live value on the first
   // half and the sample on the second half; reserved bits read zero
   // so software can compare whole words
   always_comb begin
      case (byte_ofs)
         `SMC_OFS_TIMER_CFG:   rd_word = {2'b00, q.tmr_run, {`SMC_CFG_RSVD_W{1'b0}},
                                          q.tmr_load};
         `SMC_OFS_TIMER_VIEW:  rd_word = {`SMC_ZERO16, q.tmr_cnt};
         `SMC_OFS_WORD_ORDER:  rd_word = q.swap;
         `SMC_OFS_FREE_TICK:   rd_word = q.free_held ? q.free_snap
                                                     : q.free_cnt;
         `SMC_OFS_DROP_TALLY:  rd_word = q.drop_held ? q.drop_snap
                                                     : q.drop_cnt;
         `SMC_OFS_INNER_CMD:   rd_word = {(q.xfer == SMC_XFER_WAIT), q.cmd_rnw,
                                          {`SMC_CMD_RSVD_W{1'b0}}, q.cmd_addr};
         `SMC_OFS_INNER_VALUE: rd_word = q.inner_value;
         default:              rd_word = `SMC_ZERO32;
      endcase
      rd_half = upper_sel ? rd_word[31:16] : rd_word[15:0];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Every flop holds unless a branch below says otherwise; pulses are
   // cleared first so each lasts exactly one clock
   always_comb begin
      d = q;
      d.drop_half     = 1'b0;
      d.tmr_expired   = 1'b0;
      d.rx_word_valid = 1'b0;

      // Slow count enable, one pulse per 25MHz period; registered so the
      // counters see a clean enable rather than a wide compare
      d.tick = (q.tick_div == DIV_LAST);
      d.tick_div = d.tick ? 4'h0 : q.tick_div + 4'h1;

      // Tick counter: no power-state gating, it always runs
      // Plain 32-bit add, so the wrap to zero comes for free
      if (q.tick) begin
         d.free_cnt = q.free_cnt + `SMC_ONE32;
      end

      // Host reads; data lands in the read flop one clock later, and a
      // held strobe counts as one read per clock
      if (rd_hit) begin
         d.rdata = rd_half;
         if (byte_ofs == `SMC_OFS_FREE_TICK) begin
            // Sample on first half so both halves are coherent
            if (!q.free_held) begin
               d.free_snap = q.free_cnt;
               d.free_held = 1'b1;
            end else begin
               d.free_held = 1'b0;
            end
         end
         if (byte_ofs == `SMC_OFS_DROP_TALLY) begin
            // Clear on the first half; the second half reads the sample
            if (!q.drop_held) begin
               d.drop_snap = q.drop_cnt;
               d.drop_cnt  = `SMC_ZERO32;
               d.drop_held = 1'b1;
            end else begin
               d.drop_held = 1'b0;
            end
         end
      end

      // Drop counting after any clear so a coincident drop survives;
      // the halfway compare uses the new value so the step is seen once
      if (frame_dropped) begin
         d.drop_cnt  = d.drop_cnt + `SMC_ONE32;
         d.drop_half = (d.drop_cnt == `SMC_DROP_HALFWAY + `SMC_ONE32);
      end

      // Host writes; each half lands on its own, so a 32-bit value is
      // only whole once both halves have been written
      if (wr_hit) begin
         case (byte_ofs)
            `SMC_OFS_TIMER_CFG: begin
               if (upper_sel) begin
                  d.tmr_run = host_wdata[`SMC_HALF_RUN_BIT];
                  if (!q.tmr_run && d.tmr_run) begin
                     d.tmr_cnt = q.tmr_load;
                  end
               end else begin
                  d.tmr_load = host_wdata;
               end
            end
            `SMC_OFS_WORD_ORDER: begin
               // Swap takes hold only once both halves hold all ones
               if (upper_sel) begin
                  d.swap[31:16] = host_wdata;
               end else begin
                  d.swap[15:0] = host_wdata;
               end
            end
            `SMC_OFS_INNER_CMD: begin
               // Writes while busy are dropped to protect the transfer
               if (q.xfer == SMC_XFER_IDLE) begin
                  if (upper_sel) begin
                     d.cmd_rnw = host_wdata[`SMC_HALF_RNW_BIT];
                     if (host_wdata[`SMC_HALF_BUSY_BIT]) begin
                        d.xfer      = SMC_XFER_WAIT;
                        d.inner_req = 1'b1;
                     end
                  end else begin
                     d.cmd_addr = host_wdata[7:0];
                  end
               end
            end
            `SMC_OFS_INNER_VALUE: begin
               if (q.xfer == SMC_XFER_IDLE) begin
                  if (upper_sel) begin
                     d.inner_value[31:16] = host_wdata;
                  end else begin
                     d.inner_value[15:0] = host_wdata;
                  end
               end
            end
            default: begin
               // Read-only and unmapped offsets ignore writes; a read in
               // the same clock still lands
               d.rdata = d.rdata;
            end
         endcase
      end

      // Falling run bit presets the preload, whatever was written with it
      if (q.tmr_run && !d.tmr_run) begin
         d.tmr_load = `SMC_TIMER_RESET;
      end

      // Timer counts down at the slow rate and reloads from preload;
      // a preload of zero expires on every tick
      if (q.tmr_run && d.tmr_run && q.tick) begin
         if (q.tmr_cnt == `SMC_ZERO16) begin
            d.tmr_cnt     = q.tmr_load;
            d.tmr_expired = 1'b1;
         end else begin
            d.tmr_cnt = q.tmr_cnt - `SMC_ONE16;
         end
      end

      // Inner register transfer; request held until acknowledged.
      // No timeout: a far side that never answers leaves busy set,
      // which software sees as a stuck busy bit
      case (q.xfer)
         SMC_XFER_IDLE: begin
            d.inner_req = d.inner_req;
         end
         SMC_XFER_WAIT: begin
            if (inner_ack) begin
               d.xfer      = SMC_XFER_IDLE;
               d.inner_req = 1'b0;
               if (q.cmd_rnw) begin
                  d.inner_value = inner_rdata;
               end
            end
         end
         default: begin
            d.xfer      = SMC_XFER_IDLE;
            d.inner_req = 1'b0;
         end
      endcase

      // Transmit: low half goes out first, then the held high half.
      // The sink cannot stall, so a word costs two clocks and the
      // ready drop is what paces the source
      d.tx_half_valid = 1'b0;
      if (q.tx_phase) begin
         d.tx_half       = q.tx_high;
         d.tx_half_valid = 1'b1;
         d.tx_phase      = 1'b0;
         d.tx_word_ready = 1'b1;
      end else if (tx_word_valid && q.tx_word_ready) begin
         d.tx_half       = tx_word[15:0];
         d.tx_high       = tx_word[31:16];
         d.tx_half_valid = 1'b1;
         d.tx_phase      = 1'b1;
         d.tx_word_ready = 1'b0;
      end

      // Receive: first half taken is the low half. A lone half stays
      // parked until its partner arrives; there is no frame boundary
      if (rx_half_valid) begin
         if (!q.rx_have_low) begin
            d.rx_low      = rx_half;
            d.rx_have_low = 1'b1;
         end else begin
            d.rx_word       = {rx_half, q.rx_low};
            d.rx_word_valid = 1'b1;
            d.rx_have_low   = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Synchronous clear; tick counter is zero one edge after reset,
   // well inside the allowed settling time
   // Timer view and preload come out of reset as all ones, and the
   // transmit side comes out ready
   always_ff @(posedge clk) begin
      if (reset) begin
         q               <= '0;
         q.xfer          <= SMC_XFER_IDLE;
         q.tmr_load      <= `SMC_TIMER_RESET;
         q.tmr_cnt       <= `SMC_TIMER_RESET;
         q.tx_word_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------
   // Plain wires from the state struct; no logic between flop and pin
   // keeps output timing independent of the host decode
   assign host_rdata         = q.rdata;
   assign drop_halfway_event = q.drop_half;
   assign timer_expired      = q.tmr_expired;
   assign inner_req          = q.inner_req;
   assign inner_rnw          = q.cmd_rnw;
   assign inner_addr         = q.cmd_addr;
   assign inner_wdata        = q.inner_value;
   assign tx_word_ready      = q.tx_word_ready;
   assign tx_half            = q.tx_half;
   assign tx_half_valid      = q.tx_half_valid;
   assign rx_word            = q.rx_word;
   assign rx_word_valid      = q.rx_word_valid;

endmodule

// >>> dv/smc_inner_model.sv
// Purpose: Inner MAC register responder on the req/ack side
// Assumes: One request at a time, req held until ack
// Notes:   Lag input sets the answer delay
`timescale 1ns/1ps
module smc_inner_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        inner_req,
   input  wire logic        inner_rnw,
   input  wire logic [7:0]  inner_addr,
   input  wire logic [31:0] inner_wdata,
   input  wire logic [4:0]  lag,
   output logic             inner_ack,
   output logic      [31:0] inner_rdata
);
   logic [31:0] mem [256];
   int          wait_q;

   // ---------------------------------------------
   // Responder
   // ---------------------------------------------
   // Read data toggles outside ack so stale values never match
   always @(posedge clk) begin
      inner_ack <= 1'b0;
      inner_rdata <= reset ? 32'h0 : ~inner_rdata;
      if (reset || !inner_req || inner_ack) begin
         wait_q <= 0;
      end else if (wait_q >= int'(lag)) begin
         inner_ack <= 1'b1;
         if (inner_rnw) begin
            inner_rdata <= mem[inner_addr];
         end else begin
            mem[inner_addr] <= inner_wdata;
         end
      end else begin
         wait_q <= wait_q + 1;
      end
   end
endmodule

// >>> dv/smc_csr_group_chk.sv
// Purpose: Port assertions for the misc CSR group
// Assumes: Sees only top module ports
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module smc_csr_group_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        host_cs,
   input wire logic        host_wr,
   input wire logic        drop_halfway_event,
   input wire logic        timer_expired,
   input wire logic        inner_req,
   input wire logic        inner_rnw,
   input wire logic [7:0]  inner_addr,
   input wire logic        inner_ack,
   input wire logic [31:0] tx_word,
   input wire logic        tx_word_valid,
   input wire logic        tx_word_ready,
   input wire logic [15:0] tx_half,
   input wire logic        tx_half_valid,
   input wire logic [15:0] rx_half,
   input wire logic        rx_half_valid,
   input wire logic [31:0] rx_word,
   input wire logic        rx_word_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   tx_low_first_a: assert property (
      tx_word_valid && tx_word_ready |=> tx_half_valid && tx_half == $past(tx_word[15:0])
      ##1 tx_half_valid && tx_half == $past(tx_word[31:16], 2))
      else $error("tx halves out of order");
   tx_ready_gap_a: assert property (
      tx_word_valid && tx_word_ready |=> !tx_word_ready ##1 tx_word_ready)
      else $error("tx ready gap wrong");
   rx_word_pack_a: assert property (
      rx_word_valid |-> $past(rx_half_valid) && rx_word[31:16] == $past(rx_half))
      else $error("rx word upper half wrong");
   req_cause_a: assert property (
      $rose(inner_req) |-> $past(host_cs && host_wr))
      else $error("inner request without write");
   req_hold_a: assert property (
      inner_req && !inner_ack |=> inner_req && $stable(inner_addr) && $stable(inner_rnw))
      else $error("inner request not held");
   req_end_a: assert property (
      inner_req && inner_ack |=> !inner_req)
      else $error("inner request not ended");
   drop_pulse_a: assert property (
      drop_halfway_event |=> !drop_halfway_event)
      else $error("halfway event too long");
   expire_pulse_a: assert property (
      timer_expired |=> !timer_expired)
      else $error("expiry pulse too long");

   // Main scenarios reached
   cover property (tx_word_valid && tx_word_ready);
   cover property (inner_ack && inner_rnw);
   cover property (rx_word_valid);
   cover property (timer_expired);
endmodule

bind smc_csr_group smc_csr_group_chk i_smc_csr_group_chk (.clk, .reset, .host_cs,
   .host_wr, .drop_halfway_event, .timer_expired, .inner_req, .inner_rnw, .inner_addr,
   .inner_ack, .tx_word, .tx_word_valid, .tx_word_ready, .tx_half, .tx_half_valid,
   .rx_half, .rx_half_valid, .rx_word, .rx_word_valid);

// >>> dv/system_misc_csr_group_test.sv
// Purpose: Self-checking bench of the misc CSR group
// Assumes: Inputs change on the falling edge
// Notes:   Random values from a fixed seed
`timescale 1ns/1ps
module system_misc_csr_group_test;
   logic        clk = 1'b0;
   logic        reset, host_cs, host_rd, host_wr, frame_dropped, inner_ack;
   logic [7:1]  host_addr;
   logic [15:0] host_wdata, host_rdata, tx_half, rx_half;
   logic        drop_halfway_event, timer_expired, inner_req, inner_rnw;
   logic [7:0]  inner_addr;
   logic [31:0] inner_wdata, inner_rdata, tx_word, rx_word;
   logic        tx_word_valid, tx_word_ready, tx_half_valid, rx_half_valid, rx_word_valid;
   logic [4:0]  lag;
   logic        swp;
   int          seed, mismatches, num_checks;

   always #2 clk = ~clk;

   smc_csr_group i_smc_csr_group (.clk, .reset, .host_cs, .host_rd, .host_wr,
      .host_addr, .host_wdata, .host_rdata, .frame_dropped, .drop_halfway_event,
      .timer_expired, .inner_req, .inner_rnw, .inner_addr, .inner_wdata, .inner_ack,
      .inner_rdata, .tx_word, .tx_word_valid, .tx_word_ready, .tx_half, .tx_half_valid,
      .rx_half, .rx_half_valid, .rx_word, .rx_word_valid);
   smc_inner_model i_smc_inner_model (.clk, .reset, .inner_req, .inner_rnw, .inner_addr,
      .inner_wdata, .lag, .inner_ack, .inner_rdata);

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Half address as the word order maps it
   function automatic logic [7:0] ha(input logic [7:0] a, input bit up);
      return {a[7:2], up ^ swp, 1'b0};
   endfunction

   // One idle clock before each access, so strobes dropped by the last
   // access never rise again in the same time step
   task automatic acc(input bit w, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      host_cs = 1'b1;
      host_rd = !w;
      host_wr = w;
      host_addr = a[7:1];
      host_wdata = d;
      @(negedge clk);
      host_cs = 1'b0;
      host_rd = 1'b0;
      host_wr = 1'b0;
   endtask

   // Low half first, so the command address lands before busy
   task automatic wr32(input logic [7:0] a, input logic [31:0] v);
      acc(1'b1, ha(a, 1'b0), v[15:0]);
      acc(1'b1, ha(a, 1'b1), v[31:16]);
   endtask

   task automatic rd32(input logic [7:0] a, output logic [31:0] v);
      acc(1'b0, ha(a, 1'b0), 16'h0);
      v[15:0] = host_rdata;
      acc(1'b0, ha(a, 1'b1), 16'h0);
      v[31:16] = host_rdata;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Wait for busy to drop before touching command or value again
   task automatic poll();
      int n;
      n = 0;
      do begin
         acc(1'b0, ha(8'hA4, 1'b1), 16'h0);
         n++;
      end while (host_rdata[15] !== 1'b0 && n < 60);
      chk(32'(host_rdata[15]), 32'h0, "busy stuck");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      logic [31:0] v, w;
      int n;
      {reset, swp, lag, seed} = {1'b1, 1'b0, 5'h0, 32'h6FB4};
      {host_cs, host_rd, host_wr, host_addr, host_wdata, frame_dropped} = '0;
      {tx_word, tx_word_valid, rx_half, rx_half_valid} = '0;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      rd32(8'h9C, v);
      chk(v, 32'h0, "tick after reset");
      repeat (398) @(negedge clk);
      rd32(8'h9C, w);
      chk(32'((w - v) inside {[39:41]}), 32'h1, "tick rate");
      rd32(8'h90, v);
      chk(v, 32'h0000_FFFF, "timer view");
      acc(1'b1, 8'hA0, 16'h5555);
      rd32(8'hA0, v);
      chk(v, 32'h0, "tally");
      acc(1'b0, 8'hF0, 16'h0);
      chk(32'(host_rdata), 32'h0, "unmapped");
      $display("test reset and tick done");
      n = 1 + ($unsigned($random(seed)) % 40);
      frame_dropped = 1'b1;
      repeat (n) @(negedge clk);
      frame_dropped = 1'b0;
      rd32(8'hA0, v);
      chk(v, 32'(n), "drop count");
      chk(32'(drop_halfway_event), 32'h0, "early halfway event");
      frame_dropped = 1'b1;
      acc(1'b0, 8'hA0, 16'h0);
      frame_dropped = 1'b0;
      acc(1'b0, 8'hA2, 16'h0);
      rd32(8'hA0, v);
      chk(v, 32'h1, "drop during clear");
      $display("test drops done");
      acc(1'b1, 8'h8C, 16'h1234);
      acc(1'b0, 8'h8C, 16'h0);
      chk(32'(host_rdata), 32'h1234, "plain order");
      wr32(8'h98, 32'hFFFF_FFFF);
      swp = 1'b1;
      rd32(8'h98, v);
      chk(v, 32'hFFFF_FFFF, "swap value");
      acc(1'b0, 8'h8E, 16'h0);
      chk(32'(host_rdata), 32'h1234, "swapped order");
      acc(1'b1, 8'h98, 16'h0);
      acc(1'b1, 8'h98, 16'h0);
      swp = 1'b0;
      rd32(8'h98, v);
      chk(v, 32'h0, "swap undone");
      $display("test word order done");
      wr32(8'h8C, 32'h2000_0003);
      n = 0;
      while (timer_expired !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk(32'(timer_expired), 32'h1, "timer expiry");
      rd32(8'h90, v);
      chk(32'(v <= 32'h3), 32'h1, "timer count");
      wr32(8'h8C, 32'h0);
      rd32(8'h8C, v);
      chk(v, 32'h0000_FFFF, "preload preset");
      $display("test timer done");
      for (int k = 0; k < 6; k++) begin
         w = $random(seed);
         v = $random(seed);
         lag = (k == 0) ? 5'h0 : 5'($random(seed));
         wr32(8'hA8, w);
         wr32(8'hA4, {2'b10, 22'h0, v[7:0]});
         poll();
         wr32(8'hA8, ~w);
         wr32(8'hA4, {2'b11, 22'h0, v[7:0]});
         poll();
         rd32(8'hA8, v);
         chk(v, w, "inner read back");
      end
      $display("test inner path done");
      for (int k = 0; k < 4; k++) begin
         tx_word = $random(seed);
         tx_word_valid = 1'b1;
         @(negedge clk);
         chk(32'(tx_half), 32'(tx_word[15:0]), "tx low");
         @(negedge clk);
         chk(32'(tx_half), 32'(tx_word[31:16]), "tx high");
      end
      tx_word_valid = 1'b0;
      for (int k = 0; k < 4; k++) begin
         w = $random(seed);
         rx_half_valid = 1'b1;
         rx_half = w[15:0];
         @(negedge clk);
         rx_half = w[31:16];
         @(negedge clk);
         rx_half_valid = 1'b0;
         rx_half = ~rx_half;
         n = 0;
         while (rx_word_valid !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
         end
         chk(rx_word, w, "rx word");
         chk(32'(rx_word_valid), 32'h1, "rx word valid");
         @(negedge clk);
      end
      $display("test fifo order done");
      print_verdict();
   end
endmodule
